// >>> rtl/headphone_dc_offset_servo_ctrl.sv
// two-channel headphone dc offset servo control with an axi4-lite register slave
`timescale 1ns/1ps
// Overview of operation
// - control bit 0 enables the left servo, bit 1 the right servo.
// - correction triggers are accepted only while that channel's enable is set.
// - writing 1 to bit 4 or 5 starts a measured start-up correction.
// - start-up correction drives the output to within 1mV of analogue ground.
// - after start-up, the measured correction is held until commanded otherwise.
// - start-up correction takes about 86ms per channel.
// - start-up trigger bit reads 1 while start-up correction is in progress.
// - writing 1 to bit 2 or 3, with that channel's bit 4 or 5 at 0, loads the stored correction without measuring.
// - stored-value correction takes about 2ms per channel.
// - stored-value trigger bit reads 1 while that correction is in progress.
// - two 8-bit two's complement stored values, right 15:8, left 7:0.
// - status bits 1:0 show start-up completion, bit 0 left.
// - status bits 5:4 show stored-value completion, bit 4 left.
// - status bits 9:8 are the OR of both completion bits per channel.
module headphone_dc_offset_servo_ctrl #(
    parameter int STARTUP_CYCLES = dc_servo_pkg::STARTUP_CYCLES,
    parameter int STORED_CYCLES = dc_servo_pkg::STORED_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dc_servo_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dc_servo_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] left_measured_offset,
    input wire logic [7:0] right_measured_offset,
    output logic [7:0] left_correction,
    output logic [7:0] right_correction,
    output logic left_servo_active,
    output logic right_servo_active
);
    localparam int NCH = dc_servo_pkg::NUM_CH;
    localparam int CW = dc_servo_pkg::CORR_W;
    // the counter must hold the longer of the two durations, whichever that is
    localparam int CNT_W = $clog2((STARTUP_CYCLES > STORED_CYCLES ? STARTUP_CYCLES
        : STORED_CYCLES) + 1);

    logic [NCH-1:0] enable_q;
    logic [15:0] stored_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic wr_take;
    logic rd_take;
    logic ctl_wr;
    logic [NCH-1:0] enable_d;
    logic [NCH-1:0] startup_busy;
    logic [NCH-1:0] stored_busy;
    logic [NCH-1:0] startup_done;
    logic [NCH-1:0] stored_done;
    logic [NCH*CW-1:0] corr_w;
    logic [NCH*CW-1:0] meas_w;
    logic [31:0] control_rd;
    logic [31:0] status_rd;

    // write address and data are taken together; a pending response blocks the next
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign rd_take = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = rd_take;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // only the low byte of the control register holds anything
    assign ctl_wr = wr_take && s_axi_wstrb[0] && (s_axi_awaddr == dc_servo_pkg::ADDR_CONTROL);
    assign enable_d = ctl_wr ? s_axi_wdata[dc_servo_pkg::ENABLE_LSB +: NCH] : enable_q;

    // write response: unmapped addresses answer slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= dc_servo_pkg::RESP_OKAY;
        end
        else if (wr_take)
        begin
            bvalid_q <= 1'b1;
            if (s_axi_awaddr == dc_servo_pkg::ADDR_CONTROL
                || s_axi_awaddr == dc_servo_pkg::ADDR_STORED
                || s_axi_awaddr == dc_servo_pkg::ADDR_STATUS)
                bresp_q <= dc_servo_pkg::RESP_OKAY;
            else
                bresp_q <= dc_servo_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // channel enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            enable_q <= '0;
        else
            enable_q <= enable_d;
    end

    // stored correction values, byte lanes honoured
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stored_q <= dc_servo_pkg::STORED_RESET;
        else if (wr_take && s_axi_awaddr == dc_servo_pkg::ADDR_STORED)
        begin
            if (s_axi_wstrb[0])
                stored_q[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1])
                stored_q[15:8] <= s_axi_wdata[15:8];
        end
    end

    // readback images
    always_comb
    begin
        control_rd = '0;
        control_rd[dc_servo_pkg::ENABLE_LSB +: NCH] = enable_q;
        control_rd[dc_servo_pkg::STORED_TRIG_LSB +: NCH] = stored_busy;
        control_rd[dc_servo_pkg::STARTUP_TRIG_LSB +: NCH] = startup_busy;
        status_rd = '0;
        status_rd[dc_servo_pkg::STARTUP_DONE_LSB +: NCH] = startup_done;
        status_rd[dc_servo_pkg::STORED_DONE_LSB +: NCH] = stored_done;
        status_rd[dc_servo_pkg::ANY_DONE_LSB +: NCH] = startup_done | stored_done;
    end

    // read channel: data registered at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= dc_servo_pkg::RESP_OKAY;
            rdata_q <= '0;
        end
        else if (rd_take)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= dc_servo_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                dc_servo_pkg::ADDR_CONTROL: rdata_q <= control_rd;
                dc_servo_pkg::ADDR_STORED: rdata_q <= {16'h0000, stored_q};
                dc_servo_pkg::ADDR_STATUS: rdata_q <= status_rd;
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= dc_servo_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign meas_w = {right_measured_offset, left_measured_offset};

    // one correction engine per channel
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        dc_servo_pkg::ch_state_t state_q;
        logic [CNT_W-1:0] cnt_q;
        logic [CW-1:0] meas_s1_q;
        logic [CW-1:0] meas_s2_q;
        logic [CW-1:0] corr_q;
        logic su_done_q;
        logic sv_done_q;
        logic go_su;
        logic go_sv;
        logic finish;

        // writing 0 to a trigger is a no-op; a busy channel ignores new triggers
        assign go_su = ctl_wr && enable_d[i] && state_q == dc_servo_pkg::CH_IDLE
            && s_axi_wdata[dc_servo_pkg::STARTUP_TRIG_LSB + i];
        assign go_sv = ctl_wr && enable_d[i] && state_q == dc_servo_pkg::CH_IDLE
            && !s_axi_wdata[dc_servo_pkg::STARTUP_TRIG_LSB + i]
            && s_axi_wdata[dc_servo_pkg::STORED_TRIG_LSB + i];
        assign finish = state_q != dc_servo_pkg::CH_IDLE && cnt_q == '0 && enable_d[i];

        // the measured offset comes from the analogue side: two-flop synchroniser
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                meas_s1_q <= '0;
                meas_s2_q <= '0;
            end
            else
            begin
                meas_s1_q <= meas_w[i*CW +: CW];
                meas_s2_q <= meas_s1_q;
            end
        end

        // sequencing and duration count
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                state_q <= dc_servo_pkg::CH_IDLE;
                cnt_q <= '0;
            end
            else if (!enable_d[i])
            begin
                state_q <= dc_servo_pkg::CH_IDLE;
                cnt_q <= '0;
            end
            else if (go_su)
            begin
                state_q <= dc_servo_pkg::CH_STARTUP;
                cnt_q <= CNT_W'(STARTUP_CYCLES - 1);
            end
            else if (go_sv)
            begin
                state_q <= dc_servo_pkg::CH_STORED;
                cnt_q <= CNT_W'(STORED_CYCLES - 1);
            end
            else if (finish)
            begin
                state_q <= dc_servo_pkg::CH_IDLE;
            end
            else if (state_q != dc_servo_pkg::CH_IDLE)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end

        // applied correction: measured at start-up end, or loaded stored value
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                corr_q <= '0;
            else if (finish && state_q == dc_servo_pkg::CH_STARTUP)
                corr_q <= meas_s2_q;
            else if (finish && state_q == dc_servo_pkg::CH_STORED)
                corr_q <= stored_q[i*CW +: CW];
        end

        // completion flags: a new trigger clears its own flag, disable clears both
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                su_done_q <= 1'b0;
                sv_done_q <= 1'b0;
            end
            else if (!enable_d[i])
            begin
                su_done_q <= 1'b0;
                sv_done_q <= 1'b0;
            end
            else
            begin
                if (finish && state_q == dc_servo_pkg::CH_STARTUP)
                    su_done_q <= 1'b1;
                else if (go_su)
                    su_done_q <= 1'b0;
                if (finish && state_q == dc_servo_pkg::CH_STORED)
                    sv_done_q <= 1'b1;
                else if (go_sv)
                    sv_done_q <= 1'b0;
            end
        end

        assign startup_busy[i] = state_q == dc_servo_pkg::CH_STARTUP;
        assign stored_busy[i] = state_q == dc_servo_pkg::CH_STORED;
        assign startup_done[i] = su_done_q;
        assign stored_done[i] = sv_done_q;
        assign corr_w[i*CW +: CW] = corr_q;
    end

    // correction drives to the analogue servo, held also while the channel is disabled
    assign left_correction = corr_w[0 +: CW];
    assign right_correction = corr_w[CW +: CW];
    assign left_servo_active = enable_q[0];
    assign right_servo_active = enable_q[1];
endmodule

// >>> rtl/dc_servo_pkg.sv
// constants, register map and types of the headphone dc offset servo controller
package dc_servo_pkg;
    // channel count: 0 is left, 1 is right
    localparam int NUM_CH = 2;
    // register indices as printed; the byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h54;
    localparam logic [7:0] IDX_STORED = 8'h57;
    localparam logic [7:0] IDX_STATUS = 8'h58;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STORED = {IDX_STORED, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    // control field positions (lowest bit is the left channel)
    localparam int ENABLE_LSB = 0;
    localparam int STORED_TRIG_LSB = 2;
    localparam int STARTUP_TRIG_LSB = 4;
    // stored correction fields: left in 7:0, right in 15:8
    localparam int CORR_W = 8;
    localparam logic [15:0] STORED_RESET = 16'h0000;
    // status field positions
    localparam int STARTUP_DONE_LSB = 0;
    localparam int STORED_DONE_LSB = 4;
    localparam int ANY_DONE_LSB = 8;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing: printed times in microseconds, clock rate in MHz
    localparam int CLK_MHZ = 25;
    localparam int STARTUP_TIME_US = 86000;
    localparam int STORED_TIME_US = 2000;
    localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLK_MHZ;
    localparam int STORED_CYCLES = STORED_TIME_US * CLK_MHZ;
    // per-channel correction engine state
    typedef enum logic [1:0] {CH_IDLE, CH_STARTUP, CH_STORED} ch_state_t;
endpackage

// >>> tb/servo_ctrl_asserts.sv
// concurrent checks on the register bus and enable outputs of the servo controller
`timescale 1ns/1ps
module servo_ctrl_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dc_servo_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic left_servo_active,
    input wire logic right_servo_active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // the enable outputs are registered, so they follow a control write at the next edge
    property p_enable;
        s_axi_awvalid && s_axi_awready && s_axi_wstrb[0]
            && s_axi_awaddr == dc_servo_pkg::ADDR_CONTROL
            |=> {right_servo_active, left_servo_active} == $past(s_axi_wdata[1:0]);
    endproperty
    // bus handshakes and answers, then the enable-follow check and covers
    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response missing");
    a_write_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_write_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response lingers");
    a_write_gate: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
        && s_axi_wready == s_axi_awready)
        else $error("write ready wrong");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp))
        else $error("read response dropped");
    a_read_gate: assert property (s_axi_arready == (s_axi_arvalid && !s_axi_rvalid))
        else $error("read ready wrong");
    a_enable_follow: assert property (p_enable)
        else $error("servo active does not follow enable");
    c_slave_error: cover property (s_axi_bvalid && s_axi_bresp == dc_servo_pkg::RESP_SLVERR);
    c_left_on: cover property ($rose(left_servo_active));
    c_right_off: cover property ($fell(right_servo_active));
endmodule
bind headphone_dc_offset_servo_ctrl servo_ctrl_checker servo_ctrl_checker_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .left_servo_active,
    .right_servo_active);

// >>> tb/headphone_dc_offset_servo_ctrl_tb.sv
// register-level testbench of the headphone dc offset servo controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module headphone_dc_offset_servo_ctrl_tb;
    localparam logic [9:0] C = dc_servo_pkg::ADDR_CONTROL;
    localparam logic [9:0] S = dc_servo_pkg::ADDR_STORED;
    localparam logic [9:0] T = dc_servo_pkg::ADDR_STATUS;
    localparam logic [9:0] BAD = 10'h3FC;
    localparam logic [1:0] OK = dc_servo_pkg::RESP_OKAY;
    localparam logic [1:0] ER = dc_servo_pkg::RESP_SLVERR;
    localparam int SU = 30;
    localparam int SV = 12;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [9:0] s_axi_awaddr = 10'h000;
    logic [9:0] s_axi_araddr = 10'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] left_measured_offset = 8'h5A;
    logic [7:0] right_measured_offset = 8'hF3;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] left_correction, right_correction;
    logic left_servo_active, right_servo_active;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    // short counts keep the run brief; the waits of the two-channel case below are derived from them
    headphone_dc_offset_servo_ctrl #(.STARTUP_CYCLES(SU), .STORED_CYCLES(SV))
        headphone_dc_offset_servo_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .left_measured_offset,
        .right_measured_offset, .left_correction, .right_correction, .left_servo_active,
        .right_servo_active);
    initial forever #20 aclk = ~aclk;
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // write: address and data offered together, bready held until the answer
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, r)
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, r)
    endtask
    // hang guard: the sequence needs under two hundred cycles
    initial forever
    begin
        @(posedge aclk);
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            final_report;
        end
    end
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(C, 32'h0, OK);
        rd(S, 32'h0, OK);
        rd(T, 32'h0, OK);
        rd(BAD, 32'h0, ER);
        wr(BAD, 32'h1, ER);
        wr(S, 32'h9C40, OK);
        rd(S, 32'h9C40, OK);
        // only lane 1 enabled: the right byte changes, the left byte keeps its value
        s_axi_wstrb <= 4'h2;
        wr(S, 32'h1177, OK);
        s_axi_wstrb <= 4'hF;
        rd(S, 32'h1140, OK);
        // a trigger with its channel disabled is dropped
        wr(C, 32'h04, OK);
        rd(C, 32'h0, OK);
        wr(C, 32'h05, OK);
        rd(C, 32'h05, OK);
        repeat (20) @(posedge aclk);
        rd(C, 32'h01, OK);
        rd(T, 32'h110, OK);
        `CHK(left_correction, 8'h40)
        // measured offsets stay fixed: the path is muted, shorted and otherwise fully up
        wr(C, 32'h23, OK);
        rd(C, 32'h23, OK);
        `CHK(right_servo_active, 1'b1)
        repeat (40) @(posedge aclk);
        rd(C, 32'h03, OK);
        rd(T, 32'h312, OK);
        `CHK(right_correction, 8'hF3)
        // status is read-only: the write is accepted and ignored
        wr(T, 32'hFFFF, OK);
        rd(T, 32'h312, OK);
        wr(C, 32'h01, OK);
        rd(T, 32'h110, OK);
        `CHK(right_correction, 8'hF3)
        `CHK(right_servo_active, 1'b0)
        // both channels together: right loads its stored byte, left start-up beats stored
        wr(C, 32'h1F, OK);
        rd(C, 32'h1B, OK);
        // reads below are taken exactly at the last busy edge and two edges later
        repeat (SV - 4) @(posedge aclk);
        rd(C, 32'h1B, OK);
        rd(C, 32'h13, OK);
        repeat (SU - SV - 4) @(posedge aclk);
        rd(C, 32'h13, OK);
        rd(C, 32'h03, OK);
        rd(T, 32'h331, OK);
        `CHK(left_correction, 8'h5A)
        `CHK(right_correction, 8'h11)
        // abort a running start-up by dropping the enable
        wr(C, 32'h11, OK);
        rd(C, 32'h11, OK);
        wr(C, 32'h0, OK);
        rd(C, 32'h0, OK);
        rd(T, 32'h0, OK);
        final_report;
    end
endmodule
